// *** rtl/iuc_pkg.sv ***
// Constants, register layout and carrier types of the IP/UDP/ACH comparator.
// Assumes an APB master on pclk and neighbouring comparator stages on pclk.
//
// What this block does
// - Two instances, usable at stages 2-4
// - One format each; UDP optional after IP
// - UDP expected only after innermost IP; udp_en is not tied to innermost
// - IPv4 header length checks next offset
// - UDP ports checked, shared by all flows
// - Flow hit on source, destination or either
// - Address compare 32 or 128 bits wide
// - Check field widths 4, 8, 32, 64 bits
// - Zero IPv4 UDP checksum on ingress only
// - No IPv4 options or fragments handled
// - IPv6 next header checks following protocol
// - Innermost IPv6 keeps checksum via pad bytes
// - IPv6 extension headers are not parsed
// - ACH checked as protocol, no flows
// - ACH accepted right after MPLS stack
// - IPSec presence by one match/mask pair
// - IPSec before UDP or at payload start
// - IPSec: no egress change, two-step only
// - IPSec ingress: reserved bytes or CRC replace
// - Match/mask pairs compare masked bits only; zero mask disables
// - Three-bit next-stage pointer, some reserved
package iuc_pkg;
   localparam logic [11:0] IUC_CTRL_ADDR  = 12'h000;
   localparam logic [11:0] IUC_OFFS_ADDR  = 12'h004;
   localparam logic [11:0] IUC_POS_ADDR   = 12'h008;
   localparam logic [11:0] IUC_UDPV_ADDR  = 12'h00C;
   localparam logic [11:0] IUC_UDPM_ADDR  = 12'h010;
   localparam logic [11:0] IUC_BVLO_ADDR  = 12'h014;
   localparam logic [11:0] IUC_BVHI_ADDR  = 12'h018;
   localparam logic [11:0] IUC_BMLO_ADDR  = 12'h01C;
   localparam logic [11:0] IUC_BMHI_ADDR  = 12'h020;
   localparam logic [11:0] IUC_STAT_ADDR  = 12'h024;
   localparam logic [1:0]  IUC_FW_EN      = 2'h0;
   localparam logic [1:0]  IUC_FW_VAL     = 2'h1;
   localparam logic [1:0]  IUC_FW_MSK     = 2'h2;
   localparam logic [1:0]  IUC_FMT_IPV4   = 2'h0;
   localparam logic [1:0]  IUC_FMT_IPV6   = 2'h1;
   localparam logic [1:0]  IUC_HIT_SRC    = 2'h1;
   localparam logic [1:0]  IUC_HIT_DST    = 2'h2;
   localparam logic [1:0]  IUC_HIT_ANY    = 2'h3;
   localparam logic [3:0]  IUC_VER4       = 4'h4;
   localparam logic [3:0]  IUC_VER6       = 4'h6;
   localparam logic [15:0] IUC_V4_FLAGS   = 16'h0006;
   localparam logic [15:0] IUC_V4_FRAG    = 16'h0007;
   localparam logic [15:0] IUC_V4_MIN     = 16'h0008;
   localparam logic [15:0] IUC_UDP_LEN    = 16'h0008;
   localparam logic [15:0] IUC_B_LEN      = 16'h0008;
   localparam logic [15:0] IUC_ADDR4_LEN  = 16'h0004;
   localparam logic [15:0] IUC_ADDR6_LEN  = 16'h0010;
   localparam logic [2:0]  IUC_PTR_RST    = 3'h5;
   localparam logic [7:0]  IUC_PTR_OK_SET = 8'h2E;

   typedef struct packed {
      logic [18:0] rsvd;
      logic        ts_into_crc;
      logic        ipsec_sel;
      logic [2:0]  following_stage_pointer;
      logic        innermost;
      logic        csum_update;
      logic        csum_clear;
      logic        udp_en;
      logic [1:0]  hit_mode;
      logic [1:0]  protocol_format_select;
   } iuc_ctrl_t;

   typedef struct packed {
      logic [7:0] protocol_compare_mask_a;
      logic [7:0] protocol_compare_value_a;
      logic [7:0] csum_off;
      logic [7:0] following_header_offset;
   } iuc_offs_t;

   typedef struct packed {
      logic [10:0] rsvd_c;
      logic [4:0]  flow_off;
      logic        rsvd_b;
      logic [6:0]  off_b;
      logic [2:0]  rsvd_a;
      logic [4:0]  off_a;
   } iuc_pos_t;

   typedef struct packed {
      logic       valid;
      logic [7:0] data;
      logic       sof;
      logic       eof;
      logic [7:0] hdr_offset;
      logic       ingress;
   } iuc_byte_t;

   typedef struct packed {
      logic       valid;
      logic       proto_ok;
      logic [2:0] next_ptr;
      logic [8:0] next_offset;
      logic [8:0] csum_pos;
      logic       pad_update;
      logic       two_step_only;
      logic       ts_into_crc;
   } iuc_result_t;
endpackage

// *** rtl/iuc_comparator.sv ***
// IP/UDP/ACH header comparator stage with its APB register file.
// Assumes a byte stream from the previous stage on pclk, one byte per valid.
//
// Chosen here: the APB register port and the address map.
`timescale 1ns/1ps
module iuc_comparator #(
   parameter int NF = 2
) (
   input  wire logic                pclk,
   input  wire logic                presetn,
   input  wire logic [11:0]         paddr,
   input  wire logic                psel,
   input  wire logic                penable,
   input  wire logic                pwrite,
   input  wire logic [31:0]         pwdata,
   output logic      [31:0]         prdata,
   output logic                     pready,
   output logic                     pslverr,
   input  wire iuc_pkg::iuc_byte_t  in_byte,
   output iuc_pkg::iuc_byte_t       out_byte,
   output iuc_pkg::iuc_result_t     result,
   output logic      [NF-1:0]       flow_hit
);
   // Flows sit at 0x40 steps from 0x040; index field limits NF to 63
   typedef struct packed {
      logic                  pready;
      logic                  pslverr;
      logic [31:0]           prdata;
      iuc_pkg::iuc_ctrl_t    ctrl;
      iuc_pkg::iuc_offs_t    offs;
      iuc_pkg::iuc_pos_t     pos;
      logic [31:0]           udp_val;
      logic [31:0]           udp_msk;
      logic [63:0]           b_val;
      logic [63:0]           b_msk;
      logic [NF-1:0]         fl_en;
      logic [NF-1:0][127:0]  fl_val;
      logic [NF-1:0][127:0]  fl_msk;
      logic [15:0]           cnt;
      logic [7:0]            hoff;
      logic                  active;
      logic                  bad;
      logic [NF-1:0]         src_bad;
      logic [NF-1:0]         dst_bad;
      iuc_pkg::iuc_byte_t    ob;
      iuc_pkg::iuc_result_t  res;
      logic [NF-1:0]         hit;
   } iuc_state_t;

   iuc_state_t s_q;
   iuc_state_t s_d;

   function automatic logic iuc_miss(input logic [7:0] b,
                                     input logic [7:0] v,
                                     input logic [7:0] m);
      return |((b ^ v) & m);
   endfunction

   always_comb
   begin
      logic        addr_ok;
      logic [31:0] rd;
      logic [1:0]  fw;
      logic [1:0]  fsel;
      logic [15:0] idx;
      logic [15:0] rel;
      logic [7:0]  off;
      logic        in_hdr;
      logic [15:0] nxt;
      logic [15:0] alen;
      logic [15:0] fo;
      logic [15:0] last;
      logic [15:0] ob_lo;
      logic [15:0] cs;
      logic [3:0]  bi;
      logic [2:0]  kb;
      logic [1:0]  ku;
      logic        src_ok;
      logic        dst_ok;
      logic        ptr_ok;
      logic        done;
      addr_ok = 1'b1;
      rd      = 32'h0;
      fw      = paddr[5:4];
      fsel    = paddr[3:2];
      idx     = 16'h0;
      rel     = 16'h0;
      off     = 8'h0;
      in_hdr  = 1'b0;
      nxt     = {8'h0, s_q.offs.following_header_offset};
      alen    = s_q.ctrl.protocol_format_select[0] ? iuc_pkg::IUC_ADDR6_LEN
                                                   : iuc_pkg::IUC_ADDR4_LEN;
      fo      = {11'h0, s_q.pos.flow_off};
      ob_lo   = {9'h0, s_q.pos.off_b};
      cs      = {8'h0, s_q.offs.csum_off};
      last    = 16'h1;
      bi      = 4'h0;
      kb      = 3'h0;
      ku      = 2'h0;
      src_ok  = 1'b0;
      dst_ok  = 1'b0;
      done    = 1'b0;
      ptr_ok  = iuc_pkg::IUC_PTR_OK_SET[s_q.ctrl.following_stage_pointer];
      s_d     = s_q;

      // Register read mux and address decode
      case (paddr)
         iuc_pkg::IUC_CTRL_ADDR: rd = s_q.ctrl;
         iuc_pkg::IUC_OFFS_ADDR: rd = s_q.offs;
         iuc_pkg::IUC_POS_ADDR:  rd = s_q.pos;
         iuc_pkg::IUC_UDPV_ADDR: rd = s_q.udp_val;
         iuc_pkg::IUC_UDPM_ADDR: rd = s_q.udp_msk;
         iuc_pkg::IUC_BVLO_ADDR: rd = s_q.b_val[31:0];
         iuc_pkg::IUC_BVHI_ADDR: rd = s_q.b_val[63:32];
         iuc_pkg::IUC_BMLO_ADDR: rd = s_q.b_msk[31:0];
         iuc_pkg::IUC_BMHI_ADDR: rd = s_q.b_msk[63:32];
         iuc_pkg::IUC_STAT_ADDR:
            rd = 32'({s_q.hit, s_q.res.two_step_only, s_q.res.proto_ok});
         default:
         begin
            addr_ok = 1'b0;
            for (int f = 0; f < NF; f++)
            begin
               if (paddr[11:6] == 6'(f + 1) && paddr[1:0] == 2'h0)
               begin
                  addr_ok = 1'b1;
                  if (fw == iuc_pkg::IUC_FW_EN && fsel == 2'h0)
                     rd = {31'h0, s_q.fl_en[f]};
                  else if (fw == iuc_pkg::IUC_FW_VAL)
                     rd = s_q.fl_val[f][32*fsel +: 32];
                  else if (fw == iuc_pkg::IUC_FW_MSK)
                     rd = s_q.fl_msk[f][32*fsel +: 32];
                  else
                     addr_ok = 1'b0;
               end
            end
         end
      endcase

      // Answer one cycle after setup; pready is a flop
      s_d.pready  = 1'b0;
      s_d.pslverr = 1'b0;
      if (psel && !penable && !s_q.pready)
      begin
         s_d.pready  = 1'b1;
         s_d.pslverr = !addr_ok;
         s_d.prdata  = addr_ok ? rd : 32'h0;
      end
      if (psel && penable && s_q.pready && pwrite && !s_q.pslverr)
      begin
         case (paddr)
            iuc_pkg::IUC_CTRL_ADDR: s_d.ctrl         = pwdata;
            iuc_pkg::IUC_OFFS_ADDR: s_d.offs         = pwdata;
            iuc_pkg::IUC_POS_ADDR:  s_d.pos          = pwdata;
            iuc_pkg::IUC_UDPV_ADDR: s_d.udp_val      = pwdata;
            iuc_pkg::IUC_UDPM_ADDR: s_d.udp_msk      = pwdata;
            iuc_pkg::IUC_BVLO_ADDR: s_d.b_val[31:0]  = pwdata;
            iuc_pkg::IUC_BVHI_ADDR: s_d.b_val[63:32] = pwdata;
            iuc_pkg::IUC_BMLO_ADDR: s_d.b_msk[31:0]  = pwdata;
            iuc_pkg::IUC_BMHI_ADDR: s_d.b_msk[63:32] = pwdata;
            iuc_pkg::IUC_STAT_ADDR: s_d.ctrl         = s_q.ctrl;
            default:
            begin
               for (int f = 0; f < NF; f++)
               begin
                  if (paddr[11:6] == 6'(f + 1))
                  begin
                     if (fw == iuc_pkg::IUC_FW_EN)
                        s_d.fl_en[f] = pwdata[0];
                     else if (fw == iuc_pkg::IUC_FW_VAL)
                        s_d.fl_val[f][32*fsel +: 32] = pwdata;
                     else if (fw == iuc_pkg::IUC_FW_MSK)
                        s_d.fl_msk[f][32*fsel +: 32] = pwdata;
                  end
               end
            end
         endcase
      end

      // Last header byte that any enabled check needs
      if (s_q.ctrl.udp_en)
         last = nxt + iuc_pkg::IUC_UDP_LEN;
      else
         last = nxt;
      if (s_q.ctrl.hit_mode != 2'h0 && fo + alen + alen > last)
         last = fo + alen + alen;
      if (s_q.b_msk != 64'h0 && ob_lo + iuc_pkg::IUC_B_LEN > last)
         last = ob_lo + iuc_pkg::IUC_B_LEN;
      if ({11'h0, s_q.pos.off_a} + 16'h1 > last)
         last = {11'h0, s_q.pos.off_a} + 16'h1;
      if (s_q.ctrl.protocol_format_select == iuc_pkg::IUC_FMT_IPV4
          && iuc_pkg::IUC_V4_MIN > last)
         last = iuc_pkg::IUC_V4_MIN;

      // Byte stream: one byte in, one byte out a cycle later, no stall
      s_d.ob        = in_byte;
      s_d.res.valid = 1'b0;
      if (in_byte.valid)
      begin
         idx = in_byte.sof ? 16'h0 : s_q.cnt;
         off = in_byte.sof ? in_byte.hdr_offset : s_q.hoff;
         if (in_byte.sof)
         begin
            s_d.hoff    = in_byte.hdr_offset;
            s_d.active  = 1'b1;
            s_d.bad     = 1'b0;
            s_d.src_bad = '0;
            s_d.dst_bad = '0;
         end
         s_d.cnt = (idx == 16'hFFFF) ? idx : idx + 16'h1;
         in_hdr  = (in_byte.sof || s_q.active) && idx >= {8'h0, off};
         rel     = idx - {8'h0, off};
      end

      if (in_hdr)
      begin
         // Version and IPv4 header length in words
         if (s_q.ctrl.protocol_format_select == iuc_pkg::IUC_FMT_IPV4)
         begin
            if (rel == 16'h0 && (in_byte.data[7:4] != iuc_pkg::IUC_VER4
                || {2'h0, in_byte.data[3:0], 2'h0} != nxt[7:0]))
               s_d.bad = 1'b1;
            if (rel == iuc_pkg::IUC_V4_FLAGS && in_byte.data[5:0] != 6'h0)
               s_d.bad = 1'b1;
            if (rel == iuc_pkg::IUC_V4_FRAG && in_byte.data != 8'h0)
               s_d.bad = 1'b1;
         end
         if (s_q.ctrl.protocol_format_select == iuc_pkg::IUC_FMT_IPV6
             && rel == 16'h0 && in_byte.data[7:4] != iuc_pkg::IUC_VER6)
            s_d.bad = 1'b1;
         // Protocol or next header byte; extension headers just miss
         if (rel == {11'h0, s_q.pos.off_a}
             && iuc_miss(in_byte.data, s_q.offs.protocol_compare_value_a,
                         s_q.offs.protocol_compare_mask_a))
            s_d.bad = 1'b1;
         // Wide pair: whole ACH header or IPSec presence
         if (rel >= ob_lo && rel < ob_lo + iuc_pkg::IUC_B_LEN)
         begin
            kb = 3'(rel - ob_lo);
            if (iuc_miss(in_byte.data, s_q.b_val[8*(7-kb) +: 8],
                         s_q.b_msk[8*(7-kb) +: 8]))
               s_d.bad = 1'b1;
         end
         // UDP ports follow the header at the programmed offset
         if (s_q.ctrl.udp_en && rel >= nxt && rel < nxt + 16'h4)
         begin
            ku = 2'(rel - nxt);
            if (iuc_miss(in_byte.data, s_q.udp_val[8*(3-ku) +: 8],
                         s_q.udp_msk[8*(3-ku) +: 8]))
               s_d.bad = 1'b1;
         end
         // Per-flow source then destination address
         for (int f = 0; f < NF; f++)
         begin
            if (rel >= fo && rel < fo + alen)
            begin
               bi = 4'(alen - 16'h1 - (rel - fo));
               if (iuc_miss(in_byte.data, s_q.fl_val[f][8*bi +: 8],
                            s_q.fl_msk[f][8*bi +: 8]))
                  s_d.src_bad[f] = 1'b1;
            end
            if (rel >= fo + alen && rel < fo + alen + alen)
            begin
               bi = 4'(alen - 16'h1 - (rel - fo - alen));
               if (iuc_miss(in_byte.data, s_q.fl_val[f][8*bi +: 8],
                            s_q.fl_msk[f][8*bi +: 8]))
                  s_d.dst_bad[f] = 1'b1;
            end
         end
         // IPv4 UDP checksum zeroed on ingress; egress passes untouched
         if (s_q.ctrl.csum_clear && in_byte.ingress && s_q.ctrl.udp_en
             && s_q.ctrl.protocol_format_select == iuc_pkg::IUC_FMT_IPV4
             && (rel == cs || rel == cs + 16'h1))
            s_d.ob.data = 8'h0;
         done = rel + 16'h1 >= last;
      end

      // Result once the last needed byte is in; short frame fails
      if (in_byte.valid && (in_byte.sof || s_q.active)
          && (done || in_byte.eof))
      begin
         s_d.active             = 1'b0;
         s_d.res.valid          = 1'b1;
         s_d.res.proto_ok       = !s_d.bad && done && ptr_ok;
         s_d.res.next_ptr       = s_q.ctrl.following_stage_pointer;
         s_d.res.next_offset    = {1'b0, off} + {1'b0, nxt[7:0]};
         s_d.res.csum_pos       = {1'b0, off} + {1'b0, cs[7:0]};
         s_d.res.pad_update     = s_d.res.proto_ok && s_q.ctrl.innermost
            && s_q.ctrl.csum_update
            && s_q.ctrl.protocol_format_select == iuc_pkg::IUC_FMT_IPV6;
         s_d.res.two_step_only  = s_d.res.proto_ok
            && s_q.ctrl.ipsec_sel;
         s_d.res.ts_into_crc    = s_d.res.two_step_only && in_byte.ingress
            && s_q.ctrl.ts_into_crc;
         for (int f = 0; f < NF; f++)
         begin
            src_ok = !s_d.src_bad[f];
            dst_ok = !s_d.dst_bad[f];
            case (s_q.ctrl.hit_mode)
               iuc_pkg::IUC_HIT_SRC: s_d.hit[f] = src_ok;
               iuc_pkg::IUC_HIT_DST: s_d.hit[f] = dst_ok;
               iuc_pkg::IUC_HIT_ANY: s_d.hit[f] = src_ok || dst_ok;
               default:              s_d.hit[f] = 1'b0;
            endcase
            s_d.hit[f] = s_d.hit[f] && s_q.fl_en[f] && s_d.res.proto_ok;
         end
      end
   end

   // One register for the whole state; flow count set at the top
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         s_q                              <= '0;
         s_q.ctrl.following_stage_pointer <= iuc_pkg::IUC_PTR_RST;
      end
      else
         s_q <= s_d;
   end

   assign prdata   = s_q.prdata;
   assign pready   = s_q.pready;
   assign pslverr  = s_q.pslverr;
   assign out_byte = s_q.ob;
   assign result   = s_q.res;
   assign flow_hit = s_q.hit;
endmodule

// *** bench/iuc_comparator_assertions.sv ***
// Port checker for the IP/UDP/ACH comparator.
// Assumes one pclk domain with presetn active low.
`timescale 1ns/1ps
module iuc_comparator_assertions #(
   parameter int NF = 2
) (
   input wire logic                 pclk,
   input wire logic                 presetn,
   input wire logic [11:0]          paddr,
   input wire logic                 psel,
   input wire logic                 penable,
   input wire logic                 pwrite,
   input wire logic [31:0]          pwdata,
   input wire logic [31:0]          prdata,
   input wire logic                 pready,
   input wire logic                 pslverr,
   input wire iuc_pkg::iuc_byte_t   in_byte,
   input wire iuc_pkg::iuc_byte_t   out_byte,
   input wire iuc_pkg::iuc_result_t result,
   input wire logic [NF-1:0]        flow_hit
);
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);

   a_ready_setup: assert property (psel && !penable && !pready |=> pready)
      else $error("no pready after setup");
   a_ready_pulse: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("pslverr without pready");
   a_rdata_hold: assert property (!pready |-> $stable(prdata))
      else $error("prdata moved outside an answer");
   a_byte_pass: assert property (
      in_byte.valid |=> out_byte.valid && out_byte.sof == $past(in_byte.sof)
      && out_byte.eof == $past(in_byte.eof))
      else $error("byte not forwarded next cycle");
   a_egress_keep: assert property (
      in_byte.valid && !in_byte.ingress
      |=> out_byte.data == $past(in_byte.data))
      else $error("egress byte altered");
   a_result_pulse: assert property (result.valid |=> !result.valid)
      else $error("result valid longer than one cycle");
   a_hit_ok: assert property (|flow_hit |-> result.proto_ok)
      else $error("flow hit without protocol valid");
   a_hit_hold: assert property (!result.valid |-> $stable(flow_hit))
      else $error("flow hit moved without a result");
   a_ptr_rsvd: assert property (
      result.valid && result.next_ptr inside {3'h0, 3'h4, 3'h6, 3'h7}
      |-> !result.proto_ok)
      else $error("reserved pointer accepted");
endmodule

bind iuc_comparator iuc_comparator_assertions #(.NF(NF)) u_chk (
   .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
   .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .in_byte(in_byte), .out_byte(out_byte), .result(result),
   .flow_hit(flow_hit)
);

// *** bench/iuc_stage_model.sv ***
// Neighbour stages: feed header bytes, collect forwarded bytes.
// Assumes the comparator takes in_byte on each rising pclk edge.
`timescale 1ns/1ps
module iuc_stage_model (
   input  wire logic               pclk,
   output iuc_pkg::iuc_byte_t      in_byte,
   input  wire iuc_pkg::iuc_byte_t out_byte
);
   // IPv4 + UDP, ports 0x013F, checksum 0xABCD
   logic [287:0] frame;
   logic [7:0]   rx [0:35];
   int           ocnt;

   initial
   begin
      frame = {96'h450000300000000040110000,
               96'hC0A80001C0A80002013F013F,
               96'h001CABCD0000000000000000};
      in_byte = '0;
      ocnt = 0;
   end

   always @(posedge pclk)
   begin
      if (out_byte.valid === 1'b1)
      begin
         rx[out_byte.sof ? 0 : ocnt] <= out_byte.data;
         ocnt <= out_byte.sof ? 1 : ocnt + 1;
      end
   end

   // No gaps; idle line shows the inverse so stale data is caught
   task automatic send(input logic ing, input logic [7:0] b0);
      logic [7:0] b;
      begin
         for (int i = 0; i < 36; i++)
         begin
            b = (i == 0) ? b0 : frame[287-8*i -: 8];
            if (!ing && (i == 26 || i == 27))
               b = 8'h00;
            @(posedge pclk);
            in_byte <= '{valid: 1'b1, data: b, sof: i == 0, eof: i == 35,
                         hdr_offset: 8'h00, ingress: ing};
         end
         @(posedge pclk);
         in_byte <= '{valid: 1'b0, data: ~b, sof: 1'b0, eof: 1'b0,
                      hdr_offset: 8'hFF, ingress: ~ing};
      end
   endtask
endmodule

// *** bench/iuc_comparator_tb.sv ***
// Bench for the IP/UDP/ACH comparator: APB set-up, frames, verdict.
// Assumes iuc_stage_model as neighbours and the bound port checker.
`timescale 1ns/1ps
module iuc_comparator_tb;
   logic                 pclk;
   logic                 presetn;
   logic [11:0]          paddr;
   logic                 psel;
   logic                 penable;
   logic                 pwrite;
   logic [31:0]          pwdata;
   logic [31:0]          prdata;
   logic                 pready;
   logic                 pslverr;
   iuc_pkg::iuc_byte_t   in_byte;
   iuc_pkg::iuc_byte_t   out_byte;
   iuc_pkg::iuc_result_t result;
   logic [1:0]           flow_hit;
   logic                 got;
   int                   vat;
   int                   n_fail;
   int                   n_tests;

   iuc_comparator #(.NF(2)) dut (
      .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .in_byte(in_byte), .out_byte(out_byte), .result(result),
      .flow_hit(flow_hit)
   );
   iuc_stage_model up (
      .pclk(pclk), .in_byte(in_byte), .out_byte(out_byte)
   );

   always #2.5 pclk = ~pclk;

   // Old ocnt is the count before the byte forwarded now
   always @(posedge pclk)
   begin
      if (result.valid === 1'b1)
      begin
         got <= 1'b1;
         vat <= up.ocnt;
      end
   end

   task automatic check(input logic ok, input string what);
      begin
         n_tests++;
         if (ok !== 1'b1)
         begin
            n_fail++;
            $display("wrong value at %0t: %s", $time, what);
         end
      end
   endtask

   task automatic final_report;
      begin
         $display("checks %0d, mismatches %0d", n_tests, n_fail);
         if (n_fail == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
         else
            $display("TESTS FAILED");
         $finish;
      end
   endtask

   task automatic apb(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
      int k;
      begin
         @(posedge pclk);
         psel <= 1'b1;
         penable <= 1'b0;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         k = 0;
         do
         begin
            @(posedge pclk);
            k++;
         end
         while (pready !== 1'b1);
         check(k == 1, "apb answer");
         r = prdata;
         e = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      begin
         apb(1'b1, a, d, r, e);
      end
   endtask

   task automatic frame(input logic [31:0] ctrl, input logic ing,
                        input logic [7:0] b0, input logic ok,
                        input logic [1:0] hit);
      logic [7:0] x;
      logic       pad;
      logic       crc;
      begin
         pad = ok && ctrl[7:6] == 2'h3 && ctrl[1:0] == 2'h1;
         crc = ok && ctrl[12:11] == 2'h3 && ing;
         wr(12'h000, ctrl);
         got = 1'b0;
         up.send(ing, b0);
         repeat (2) @(posedge pclk);
         check(got === 1'b1 && vat == 27, "result moment");
         check(result.proto_ok === ok, "protocol valid");
         check(result.next_offset === 9'h014, "next offset");
         check(result.next_ptr === ctrl[10:8], "next pointer");
         check(flow_hit === hit, "flow hit");
         check(result.csum_pos === 9'h01A, "checksum position");
         check(result.pad_update === pad, "pad update");
         check(result.two_step_only === (ok && ctrl[11]), "two step");
         check(result.ts_into_crc === crc, "crc insert");
         for (int i = 0; i < 36; i++)
         begin
            x = (i == 0) ? b0 : up.frame[287-8*i -: 8];
            if ((i == 26 || i == 27)
                && (!ing || (ctrl[5:4] == 2'h3 && ctrl[1:0] == 2'h0)))
               x = 8'h00;
            check(up.rx[i] === x, "forwarded byte");
         end
      end
   endtask

   task automatic t_regs;
      logic [31:0] r;
      logic        e;
      begin
         apb(1'b0, 12'h000, 32'h00000000, r, e);
         check(r === 32'h00000500 && e === 1'b0, "control reset");
         wr(12'h000, 32'h0000053D);
         apb(1'b0, 12'h000, 32'h00000000, r, e);
         check(r === 32'h0000053D, "control readback");
         apb(1'b1, 12'h030, 32'hFFFFFFFF, r, e);
         check(e === 1'b1, "unmapped write");
         apb(1'b0, 12'h0C0, 32'h00000000, r, e);
         check(e === 1'b1 && r === 32'h00000000, "unmapped read");
      end
   endtask

   // Protocol A on byte 9, flow 0 on source address
   task automatic t_setup;
      begin
         wr(12'h004, 32'hFF111A14);
         wr(12'h008, 32'h000C0009);
         wr(12'h00C, 32'h013F013F);
         wr(12'h010, 32'hFFFFFFFF);
         wr(12'h040, 32'h00000001);
         wr(12'h050, 32'hC0A80001);
         wr(12'h060, 32'hFFFFFFFF);
      end
   endtask

   task automatic t_hit_modes;
      begin
         frame(32'h00000534, 1'b1, 8'h45, 1'b1, 2'b01);
         frame(32'h00000538, 1'b0, 8'h45, 1'b1, 2'b00);
         frame(32'h00000530, 1'b1, 8'h45, 1'b1, 2'b00);
      end
   endtask

   task automatic t_bad_header;
      begin
         frame(32'h0000053C, 1'b0, 8'h46, 1'b0, 2'b00);
         frame(32'h0000053C, 1'b0, 8'h55, 1'b0, 2'b00);
         frame(32'h0000053E, 1'b0, 8'h55, 1'b1, 2'b01);
         frame(32'h00000531, 1'b0, 8'h45, 1'b0, 2'b00);
         frame(32'h000005F1, 1'b0, 8'h65, 1'b1, 2'b00);
      end
   endtask

   task automatic t_pointers;
      logic ok;
      begin
         for (int p = 0; p < 8; p++)
         begin
            ok = (p == 1 || p == 2 || p == 3 || p == 5);
            frame(32'h0000003C | (32'(p) << 8), 1'b1, 8'h45, ok,
                  {1'b0, ok});
         end
      end
   endtask

   // Wide pair matches the first two header words, then one bit off
   task automatic t_ipsec;
      logic [31:0] r;
      logic        e;
      begin
         wr(12'h018, 32'h45000030);
         wr(12'h01C, 32'hFFFFFFFF);
         wr(12'h020, 32'hFFFFFFFF);
         frame(32'h00001DB4, 1'b1, 8'h45, 1'b1, 2'b01);
         frame(32'h00001DB4, 1'b0, 8'h45, 1'b1, 2'b01);
         apb(1'b0, 12'h024, 32'h00000000, r, e);
         check(r === 32'h00000007 && e === 1'b0, "status");
         wr(12'h014, 32'h00000001);
         frame(32'h00001DB4, 1'b1, 8'h45, 1'b0, 2'b00);
      end
   endtask

   // About five times the expected run
   initial
   begin
      #20000;
      n_fail++;
      final_report;
   end

   initial
   begin
      pclk = 1'b0;
      presetn = 1'b0;
      paddr = 12'h000;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      pwdata = 32'h00000000;
      got = 1'b0;
      vat = 0;
      n_fail = 0;
      n_tests = 0;
      repeat (8) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_setup;
      t_hit_modes;
      t_bad_header;
      t_pointers;
      t_ipsec;
      final_report;
   end
endmodule
